// ---- shared/sysopt_pkg.sv ----
// Package of constants and carriers for the system option register bank
package sysopt_pkg;

  // ************************************************************
  // Register indices and byte addresses
  // ************************************************************
  localparam int              SYSOPT_NREG      = 3;
  localparam logic [7:0]      SYSOPT_IDX_ONE   = 8'h1F;
  localparam logic [7:0]      SYSOPT_IDX_TWO   = 8'h1E;
  localparam logic [7:0]      SYSOPT_IDX_THREE = 8'h09;
  localparam logic [11:0]     SYSOPT_ADDR_ONE  = {2'h0, SYSOPT_IDX_ONE, 2'h0};
  localparam logic [11:0]     SYSOPT_ADDR_TWO  = {2'h0, SYSOPT_IDX_TWO, 2'h0};
  localparam logic [11:0]     SYSOPT_ADDR_THR  = {2'h0, SYSOPT_IDX_THREE, 2'h0};
  localparam logic [7:0]      SYSOPT_RST_VAL   = 8'h00;
  localparam logic [2:0][7:0] SYSOPT_WR_MASK   = {8'hFE, 8'hFE, 8'hF7};

  // ************************************************************
  // Field positions, register one
  // ************************************************************
  localparam int SYSOPT_C1_WDOG_RATE = 7;
  localparam int SYSOPT_C1_LVI_HALT  = 6;
  localparam int SYSOPT_C1_LVI_RSTD  = 5;
  localparam int SYSOPT_C1_LVI_PWRD  = 4;
  localparam int SYSOPT_C1_LVI_VSEL  = 3;
  localparam int SYSOPT_C1_SHORT_REC = 2;
  localparam int SYSOPT_C1_HALT_INS  = 1;
  localparam int SYSOPT_C1_WDOG_DIS  = 0;

  // ************************************************************
  // Field positions, registers two and three
  // ************************************************************
  localparam int SYSOPT_C2_BAUD_BUS  = 7;
  localparam int SYSOPT_C2_XTAL      = 6;
  localparam int SYSOPT_C2_EXTCLK    = 5;
  localparam int SYSOPT_C2_SLOW      = 4;
  localparam int SYSOPT_C2_TB_PRE    = 3;
  localparam int SYSOPT_C2_OSC_HALT  = 2;
  localparam int SYSOPT_C2_SS_PU_DIS = 1;
  localparam int SYSOPT_C3_RANGE     = 7;
  localparam int SYSOPT_C3_SLEW_LO   = 3;
  localparam int SYSOPT_C3_ASYNC_PIN = 2;
  localparam int SYSOPT_C3_SPI_PIN   = 1;

  // ************************************************************
  // Cycle counts and amplifier range codes handed to the consumers
  // ************************************************************
  localparam logic [12:0] SYSOPT_REC_SHORT  = 13'h0020;
  localparam logic [12:0] SYSOPT_REC_LONG   = 13'h1000;
  localparam logic [12:0] SYSOPT_STAB_XTAL  = 13'h1000;
  localparam logic [12:0] SYSOPT_STAB_CLK   = 13'h0010;
  localparam logic [2:0]  SYSOPT_AMP_FAST   = 3'h1;
  localparam logic [2:0]  SYSOPT_AMP_MID    = 3'h2;
  localparam logic [2:0]  SYSOPT_AMP_SLOW   = 3'h4;
  localparam logic [2:0]  SYSOPT_AMP_NONE   = 3'h0;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic        lvi_powered;
    logic        lvi_run_in_halt;
    logic        lvi_reset_out;
    logic [12:0] halt_recovery_cycles;
    logic        halt_instr_legal;
    logic        watchdog_enable;
    logic        watchdog_rate_select;
    logic        async_clk_from_bus;
    logic        osc_in_is_clock;
    logic        osc_out_is_crystal;
    logic [12:0] stab_cycles;
    logic        slow_crystal;
    logic        tb_prescale_en;
    logic        clocks_in_halt;
    logic        ss_pullup_en;
    logic [2:0]  amp_range_sel;
    logic [3:0]  slew_en;
    logic        async_pins_alt;
    logic        spi_pins_alt;
  } sysopt_out_s;

  typedef struct packed {
    logic [2:0][7:0] regs;
    logic [2:0]      lock;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    sysopt_out_s     outs;
  } sysopt_state_s;

endpackage

// ---- rtl/sysopt_regs.sv ----
// Write-once system option register bank on APB with static fan-out
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/100ps

// Contract
// - Monitor runs in halt when powered and halt-enable bit set; reset clears it.
// - Reset-disable bit blocks the monitor's reset request, else passes it.
// - Power-disable bit turns off monitor power and its halt run, but not its reset request path.
// - Voltage select picks 5-V or 3-V mode; only power-on reset clears it.
// - Halt exit waits 32 oscillator cycles when short recovery set, else 4096.
// - Halt exit caused by monitor reset always uses the long delay.
// - Halt instruction executes when enabled, otherwise treated as illegal opcode.
// - Watchdog disable bit holds the watchdog off; clear means enabled.
// - Async port clocks from bus clock when set, oscillator clock when clear.
// - Crystal enable works only with external clock enable; then output pin crystal.
// - External clock enable routes input pin to clock; clear leaves both pins I/O.
// - Stabilisation divider times out after 4096 with crystal, else 16 cycles.
// - Slow crystal bit selects slow crystal and low expected frequency.
// - Timebase prescale bit inserts extra divide-by-128 stage.
// - Keep-in-halt bit keeps clocks running; clear stops them low in halt.
// - Slave-select pullup on when disable bit clear, off when set.
// - Slow and range bits decode oscillator amplifier range; 11 reserved.
// - While slow crystal set, range bit forced zero and writes ignored.
// - Four slew bits select slew-controlled drive for their outputs.
// - SPI pin select picks the alternate or default SPI pin group.
// - Each register takes one write per reset, cleared by reset except voltage select, readable anytime.
module sysopt_regs
  import sysopt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        por_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        lvi_reset_req,
  input  wire logic        halt_exit_by_lvi,
  output logic             lvi_volt_5v,
  output sysopt_out_s      cfg_out
);

  // ************************************************************
  // State
  // ************************************************************
  sysopt_state_s st_q;
  sysopt_state_s st_d;
  logic          vsel_q;
  logic          vsel_d;
  logic          setup;
  logic          access;
  logic          hit;
  logic [1:0]    sel;
  logic [2:0]    wr;
  logic [7:0]    rd;
  logic [7:0]    r1;
  logic [7:0]    r2;
  logic [7:0]    r3;

  // ************************************************************
  // Address decode
  // ************************************************************
  always_comb begin
    hit = 1'b1;
    sel = 2'h0;
    case (paddr)
      SYSOPT_ADDR_ONE: sel = 2'h0;
      SYSOPT_ADDR_TWO: sel = 2'h1;
      SYSOPT_ADDR_THR: sel = 2'h2;
      default:         hit = 1'b0;
    endcase
  end

  assign setup  = psel & ~penable;
  assign access = psel & penable & st_q.pready;

  // ************************************************************
  // Per-register write strobes, gated by each lock
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < SYSOPT_NREG; g++) begin : g_wr
      assign wr[g] = access & pwrite & hit & (sel == 2'(g)) & ~st_q.lock[g];
    end
  endgenerate

  // Voltage select lives outside the main state: only power-on reset clears it
  assign vsel_d = wr[0] ? pwdata[SYSOPT_C1_LVI_VSEL] : vsel_q;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    st_d         = st_q;
    st_d.pready  = 1'b0;
    st_d.pslverr = 1'b0;
    rd           = SYSOPT_RST_VAL;
    if (setup) begin
      // Answer lands in the first access cycle: zero wait states
      rd = st_q.regs[sel];
      if (sel == 2'h0) begin
        rd[SYSOPT_C1_LVI_VSEL] = vsel_q;
      end
      st_d.pready  = 1'b1;
      st_d.pslverr = ~hit;
      st_d.prdata  = {24'h000000, rd & {8{hit}}};
    end
    for (int i = 0; i < SYSOPT_NREG; i++) begin
      if (wr[i]) begin
        st_d.regs[i] = pwdata[7:0] & SYSOPT_WR_MASK[i];
        st_d.lock[i] = 1'b1;
      end
    end
    // Range bit cannot stick while slow crystal is chosen
    if (st_d.regs[1][SYSOPT_C2_SLOW]) begin
      st_d.regs[2][SYSOPT_C3_RANGE] = 1'b0;
    end
    r1 = st_d.regs[0];
    r2 = st_d.regs[1];
    r3 = st_d.regs[2];
    st_d.outs.lvi_powered     = ~r1[SYSOPT_C1_LVI_PWRD];
    st_d.outs.lvi_run_in_halt = ~r1[SYSOPT_C1_LVI_PWRD] & r1[SYSOPT_C1_LVI_HALT];
    st_d.outs.lvi_reset_out   = lvi_reset_req & ~r1[SYSOPT_C1_LVI_RSTD];
    // Monitor reset exit ignores the short option
    if (r1[SYSOPT_C1_SHORT_REC] & ~halt_exit_by_lvi) begin
      st_d.outs.halt_recovery_cycles = SYSOPT_REC_SHORT;
    end else begin
      st_d.outs.halt_recovery_cycles = SYSOPT_REC_LONG;
    end
    st_d.outs.halt_instr_legal     = r1[SYSOPT_C1_HALT_INS];
    st_d.outs.watchdog_enable      = ~r1[SYSOPT_C1_WDOG_DIS];
    st_d.outs.watchdog_rate_select = r1[SYSOPT_C1_WDOG_RATE];
    st_d.outs.async_clk_from_bus   = r2[SYSOPT_C2_BAUD_BUS];
    st_d.outs.osc_in_is_clock      = r2[SYSOPT_C2_EXTCLK];
    st_d.outs.osc_out_is_crystal   = r2[SYSOPT_C2_EXTCLK] & r2[SYSOPT_C2_XTAL];
    // Divider follows the crystal bit alone, as the clock monitor sees it
    if (r2[SYSOPT_C2_XTAL]) begin
      st_d.outs.stab_cycles = SYSOPT_STAB_XTAL;
    end else begin
      st_d.outs.stab_cycles = SYSOPT_STAB_CLK;
    end
    st_d.outs.slow_crystal   = r2[SYSOPT_C2_SLOW];
    st_d.outs.tb_prescale_en = r2[SYSOPT_C2_TB_PRE];
    st_d.outs.clocks_in_halt = r2[SYSOPT_C2_OSC_HALT];
    st_d.outs.ss_pullup_en   = ~r2[SYSOPT_C2_SS_PU_DIS];
    case ({r2[SYSOPT_C2_SLOW], r3[SYSOPT_C3_RANGE]})
      2'h0:    st_d.outs.amp_range_sel = SYSOPT_AMP_FAST;
      2'h1:    st_d.outs.amp_range_sel = SYSOPT_AMP_MID;
      2'h2:    st_d.outs.amp_range_sel = SYSOPT_AMP_SLOW;
      default: st_d.outs.amp_range_sel = SYSOPT_AMP_NONE;
    endcase
    st_d.outs.slew_en        = r3[SYSOPT_C3_SLEW_LO +: 4];
    st_d.outs.async_pins_alt = r3[SYSOPT_C3_ASYNC_PIN];
    st_d.outs.spi_pins_alt   = r3[SYSOPT_C3_SPI_PIN];
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q                           <= '0;
      st_q.outs.lvi_powered          <= 1'b1;
      st_q.outs.halt_recovery_cycles <= SYSOPT_REC_LONG;
      st_q.outs.watchdog_enable      <= 1'b1;
      st_q.outs.stab_cycles          <= SYSOPT_STAB_CLK;
      st_q.outs.ss_pullup_en         <= 1'b1;
      st_q.outs.amp_range_sel        <= SYSOPT_AMP_FAST;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      vsel_q <= 1'b0;
    end else begin
      vsel_q <= vsel_d;
    end
  end

  assign prdata      = st_q.prdata;
  assign pready      = st_q.pready;
  assign pslverr     = st_q.pslverr;
  assign cfg_out     = st_q.outs;
  assign lvi_volt_5v = vsel_q;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  write_once_a: assert property (
    (access && pwrite && hit && st_q.lock[sel])
      |=> $stable(st_q.regs[$past(sel)])
  ) else $error("locked option register changed on write");

  lock_set_a: assert property (
    (access && pwrite && hit) |=> st_q.lock[$past(sel)]
  ) else $error("lock flag not set by write");

  apb_answer_a: assert property (
    setup |=> pready ##1 !pready
  ) else $error("pready not a single access-cycle pulse");

  unmapped_err_a: assert property (
    (setup && !hit) |=> (pslverr && prdata == 32'h00000000)
  ) else $error("unmapped address not refused");

  range_forced_a: assert property (
    st_q.regs[1][SYSOPT_C2_SLOW] |-> !st_q.regs[2][SYSOPT_C3_RANGE]
  ) else $error("range bit set while slow crystal selected");

  lvi_halt_a: assert property (
    cfg_out.lvi_run_in_halt |-> (cfg_out.lvi_powered && st_q.regs[0][SYSOPT_C1_LVI_HALT])
  ) else $error("monitor runs in halt without enable");

  lvi_reset_a: assert property (
    (lvi_reset_req && !st_d.regs[0][SYSOPT_C1_LVI_RSTD]) |=> cfg_out.lvi_reset_out
  ) else $error("monitor reset request not passed");

  recovery_lvi_a: assert property (
    halt_exit_by_lvi |=> (cfg_out.halt_recovery_cycles == SYSOPT_REC_LONG)
  ) else $error("monitor exit did not use long recovery");

  recovery_short_a: assert property (
    (!halt_exit_by_lvi && st_d.regs[0][SYSOPT_C1_SHORT_REC])
      |=> (cfg_out.halt_recovery_cycles == SYSOPT_REC_SHORT)
  ) else $error("short recovery not 32 cycles");

  stab_div_a: assert property (
    cfg_out.stab_cycles == (st_q.regs[1][SYSOPT_C2_XTAL] ? SYSOPT_STAB_XTAL : SYSOPT_STAB_CLK)
  ) else $error("stabilisation count wrong");

  crystal_pin_a: assert property (
    cfg_out.osc_out_is_crystal |-> cfg_out.osc_in_is_clock
  ) else $error("crystal pin active without clock input");

  // ************************************************************
  // Fan-out checks from the write or the next state, then read-back and bus checks
  // ************************************************************

  halt_run_a: assert property (
    wr[0] |=> cfg_out.lvi_run_in_halt
      == $past(pwdata[SYSOPT_C1_LVI_HALT] & ~pwdata[SYSOPT_C1_LVI_PWRD])
  ) else $error("monitor halt enable not taken from write");

  reset_block_a: assert property (
    st_d.regs[0][SYSOPT_C1_LVI_RSTD] |=> !cfg_out.lvi_reset_out
  ) else $error("monitor reset request not blocked");

  power_off_a: assert property (
    wr[0] |=> cfg_out.lvi_powered == !$past(pwdata[SYSOPT_C1_LVI_PWRD])
  ) else $error("monitor power not taken from write");

  volt_write_a: assert property (
    wr[0] |=> lvi_volt_5v == $past(pwdata[SYSOPT_C1_LVI_VSEL])
  ) else $error("voltage select not taken from write");

  recovery_long_a: assert property (
    !st_d.regs[0][SYSOPT_C1_SHORT_REC] |=> cfg_out.halt_recovery_cycles == SYSOPT_REC_LONG
  ) else $error("long recovery not 4096 cycles");

  halt_instr_a: assert property (
    wr[0] |=> cfg_out.halt_instr_legal == $past(pwdata[SYSOPT_C1_HALT_INS])
  ) else $error("halt instruction enable not taken from write");

  wdog_off_a: assert property (
    wr[0] |=> cfg_out.watchdog_enable == !$past(pwdata[SYSOPT_C1_WDOG_DIS])
  ) else $error("watchdog disable not taken from write");

  baud_source_a: assert property (
    wr[1] |=> cfg_out.async_clk_from_bus == $past(pwdata[SYSOPT_C2_BAUD_BUS])
  ) else $error("baud clock source not taken from write");

  crystal_write_a: assert property (
    wr[1] |=> cfg_out.osc_out_is_crystal
      == $past(pwdata[SYSOPT_C2_EXTCLK] & pwdata[SYSOPT_C2_XTAL])
  ) else $error("crystal pin not gated by clock enable");

  clock_in_a: assert property (
    wr[1] |=> cfg_out.osc_in_is_clock == $past(pwdata[SYSOPT_C2_EXTCLK])
  ) else $error("clock input pin not taken from write");

  slow_crystal_a: assert property (
    wr[1] |=> cfg_out.slow_crystal == $past(pwdata[SYSOPT_C2_SLOW])
  ) else $error("slow crystal not taken from write");

  tb_prescale_a: assert property (
    wr[1] |=> cfg_out.tb_prescale_en == $past(pwdata[SYSOPT_C2_TB_PRE])
  ) else $error("timebase prescale not taken from write");

  halt_clocks_a: assert property (
    wr[1] |=> cfg_out.clocks_in_halt == $past(pwdata[SYSOPT_C2_OSC_HALT])
  ) else $error("clocks in halt not taken from write");

  ss_pullup_a: assert property (
    wr[1] |=> cfg_out.ss_pullup_en == !$past(pwdata[SYSOPT_C2_SS_PU_DIS])
  ) else $error("pullup enable not taken from write");

  amp_fast_a: assert property (
    !st_d.regs[1][SYSOPT_C2_SLOW] && !st_d.regs[2][SYSOPT_C3_RANGE]
      |=> cfg_out.amp_range_sel == SYSOPT_AMP_FAST
  ) else $error("fast crystal range not decoded");

  amp_mid_a: assert property (
    !st_d.regs[1][SYSOPT_C2_SLOW] && st_d.regs[2][SYSOPT_C3_RANGE]
      |=> cfg_out.amp_range_sel == SYSOPT_AMP_MID
  ) else $error("mid crystal range not decoded");

  amp_slow_a: assert property (
    st_d.regs[1][SYSOPT_C2_SLOW] |=> cfg_out.amp_range_sel == SYSOPT_AMP_SLOW
  ) else $error("slow crystal range not decoded");

  range_write_a: assert property (
    wr[2] && !st_q.regs[1][SYSOPT_C2_SLOW]
      |=> st_q.regs[2][SYSOPT_C3_RANGE] == $past(pwdata[SYSOPT_C3_RANGE])
  ) else $error("range bit not taken from write");

  slew_write_a: assert property (
    wr[2] |=> cfg_out.slew_en == $past(pwdata[SYSOPT_C3_SLEW_LO +: 4])
  ) else $error("slew enables not taken from write");

  async_pins_a: assert property (
    wr[2] |=> cfg_out.async_pins_alt == $past(pwdata[SYSOPT_C3_ASYNC_PIN])
  ) else $error("async pin select not taken from write");

  spi_pins_a: assert property (
    wr[2] |=> cfg_out.spi_pins_alt == $past(pwdata[SYSOPT_C3_SPI_PIN])
  ) else $error("spi pin select not taken from write");

  read_data_a: assert property (
    setup && hit && sel != 2'h0 |=> prdata == {24'h000000, $past(st_q.regs[sel])}
  ) else $error("read data not the stored register");

  read_volt_a: assert property (
    setup && hit && sel == 2'h0 |=> prdata[SYSOPT_C1_LVI_VSEL] == $past(lvi_volt_5v)
  ) else $error("read of voltage select wrong");

  unmapped_write_a: assert property (
    access && pwrite && !hit |=> $stable(st_q.regs) && $stable(st_q.lock)
  ) else $error("unmapped write changed a register");

  lock_hold_a: assert property (
    st_q.lock == 3'h7 |=> st_q.lock == 3'h7
  ) else $error("lock flag dropped without reset");

  err_ready_a: assert property (
    pslverr |-> pready
  ) else $error("error answer without ready");

endmodule // sysopt_regs

// ---- dv/sysopt_regs_bench.sv ----
// Self-checking bench for the write-once system option register bank
`timescale 1ns/100ps

module sysopt_regs_bench
  import sysopt_pkg::*;
;
  // ************************************************************
  // Signals
  // ************************************************************
  logic        pclk;
  logic        presetn;
  logic        por_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        lvi_reset_req;
  logic        halt_exit_by_lvi;
  logic        lvi_volt_5v;
  sysopt_out_s cfg_out;
  int          err_total;
  int          comparisons;
  logic [31:0] rd;
  logic        er;

  sysopt_regs dut (
    .pclk            (pclk),
    .presetn         (presetn),
    .por_n           (por_n),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .lvi_reset_req   (lvi_reset_req),
    .halt_exit_by_lvi(halt_exit_by_lvi),
    .lvi_volt_5v     (lvi_volt_5v),
    .cfg_out         (cfg_out)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Request held until pready is sampled high; no fixed latency assumed
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                          output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED pready expected 1 seen %b", pready);
      give_verdict();
    end else begin
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb_xfer(1'b1, a, {24'h000000, d}, rd, er);
  endtask

  // Bit 3 of register one lives in its own flop, so reads mask it
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input logic [7:0] m,
                        input string what);
    apb_xfer(1'b0, a, 32'h00000000, rd, er);
    check(what, rd & {24'hFFFFFF, m}, {24'h000000, exp & m});
  endtask

  task automatic settle();
    repeat (2) @(posedge pclk);
  endtask

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    err_total = 0;
    comparisons = 0;
    presetn = 1'b0;
    por_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    lvi_reset_req = 1'b0;
    halt_exit_by_lvi = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    rd_chk(SYSOPT_ADDR_ONE, 8'h00, 8'hFF, "reg one reset");
    rd_chk(SYSOPT_ADDR_TWO, 8'h00, 8'hFF, "reg two reset");
    rd_chk(SYSOPT_ADDR_THR, 8'h00, 8'hFF, "reg three reset");
    check("powered", 32'(cfg_out.lvi_powered), 32'h1);
    check("wdog en", 32'(cfg_out.watchdog_enable), 32'h1);
    check("ss pullup", 32'(cfg_out.ss_pullup_en), 32'h1);
    check("recovery", 32'(cfg_out.halt_recovery_cycles), 32'(SYSOPT_REC_LONG));
    check("stab", 32'(cfg_out.stab_cycles), 32'(SYSOPT_STAB_CLK));
    check("amp", 32'(cfg_out.amp_range_sel), 32'(SYSOPT_AMP_FAST));
    check("volt", 32'(lvi_volt_5v), 32'h0);
    $display("Test reset values done");
    // Slow crystal goes in before the range write so that write is ignored
    wr(SYSOPT_ADDR_ONE, 8'hED);
    wr(SYSOPT_ADDR_TWO, 8'hFC);
    wr(SYSOPT_ADDR_THR, 8'hFE);
    @(posedge pclk);
    lvi_reset_req <= 1'b1;
    settle();
    check("run in halt", 32'(cfg_out.lvi_run_in_halt), 32'h1);
    check("reset out", 32'(cfg_out.lvi_reset_out), 32'h0);
    check("powered", 32'(cfg_out.lvi_powered), 32'h1);
    check("volt", 32'(lvi_volt_5v), 32'h1);
    check("recovery", 32'(cfg_out.halt_recovery_cycles), 32'(SYSOPT_REC_SHORT));
    check("halt instr", 32'(cfg_out.halt_instr_legal), 32'h0);
    check("wdog en", 32'(cfg_out.watchdog_enable), 32'h0);
    check("baud bus", 32'(cfg_out.async_clk_from_bus), 32'h1);
    check("osc out", 32'(cfg_out.osc_out_is_crystal), 32'h1);
    check("osc in", 32'(cfg_out.osc_in_is_clock), 32'h1);
    check("stab", 32'(cfg_out.stab_cycles), 32'(SYSOPT_STAB_XTAL));
    check("slow", 32'(cfg_out.slow_crystal), 32'h1);
    check("tb pre", 32'(cfg_out.tb_prescale_en), 32'h1);
    check("clk halt", 32'(cfg_out.clocks_in_halt), 32'h1);
    check("ss pullup", 32'(cfg_out.ss_pullup_en), 32'h1);
    check("amp", 32'(cfg_out.amp_range_sel), 32'(SYSOPT_AMP_SLOW));
    check("slew", 32'(cfg_out.slew_en), 32'hF);
    check("async pins", 32'(cfg_out.async_pins_alt), 32'h1);
    check("spi pins", 32'(cfg_out.spi_pins_alt), 32'h1);
    check("wdog rate", 32'(cfg_out.watchdog_rate_select), 32'h1);
    rd_chk(SYSOPT_ADDR_THR, 8'h7E, 8'hFF, "range forced");
    @(posedge pclk);
    halt_exit_by_lvi <= 1'b1;
    settle();
    check("recovery lvi", 32'(cfg_out.halt_recovery_cycles), 32'(SYSOPT_REC_LONG));
    $display("Test all options set done");
    wr(SYSOPT_ADDR_ONE, 8'h00);
    wr(SYSOPT_ADDR_TWO, 8'h00);
    rd_chk(SYSOPT_ADDR_ONE, 8'hED, 8'hF7, "reg one locked");
    rd_chk(SYSOPT_ADDR_TWO, 8'hFC, 8'hFF, "reg two locked");
    apb_xfer(1'b1, 12'h000, 32'h000000FF, rd, er);
    check("unmapped wr err", 32'(er), 32'h1);
    apb_xfer(1'b0, 12'h000, 32'h00000000, rd, er);
    check("unmapped err", 32'(er), 32'h1);
    check("unmapped data", rd, 32'h00000000);
    $display("Test write once done");
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    halt_exit_by_lvi <= 1'b0;
    rd_chk(SYSOPT_ADDR_ONE, 8'h00, 8'hF7, "reg one cleared");
    check("volt kept", 32'(lvi_volt_5v), 32'h1);
    @(posedge pclk);
    por_n <= 1'b0;
    @(posedge pclk);
    por_n <= 1'b1;
    settle();
    check("volt por", 32'(lvi_volt_5v), 32'h0);
    $display("Test resets done");
    wr(SYSOPT_ADDR_ONE, 8'h52);
    wr(SYSOPT_ADDR_TWO, 8'h42);
    wr(SYSOPT_ADDR_THR, 8'h80);
    settle();
    check("powered", 32'(cfg_out.lvi_powered), 32'h0);
    check("run in halt", 32'(cfg_out.lvi_run_in_halt), 32'h0);
    check("reset out", 32'(cfg_out.lvi_reset_out), 32'h1);
    check("recovery", 32'(cfg_out.halt_recovery_cycles), 32'(SYSOPT_REC_LONG));
    check("halt instr", 32'(cfg_out.halt_instr_legal), 32'h1);
    check("wdog en", 32'(cfg_out.watchdog_enable), 32'h1);
    check("baud bus", 32'(cfg_out.async_clk_from_bus), 32'h0);
    check("osc out", 32'(cfg_out.osc_out_is_crystal), 32'h0);
    check("osc in", 32'(cfg_out.osc_in_is_clock), 32'h0);
    check("slow", 32'(cfg_out.slow_crystal), 32'h0);
    check("tb pre", 32'(cfg_out.tb_prescale_en), 32'h0);
    check("stab", 32'(cfg_out.stab_cycles), 32'(SYSOPT_STAB_XTAL));
    check("volt", 32'(lvi_volt_5v), 32'h0);
    check("clk halt", 32'(cfg_out.clocks_in_halt), 32'h0);
    check("ss pullup", 32'(cfg_out.ss_pullup_en), 32'h0);
    check("amp", 32'(cfg_out.amp_range_sel), 32'(SYSOPT_AMP_MID));
    rd_chk(SYSOPT_ADDR_THR, 8'h80, 8'hFF, "range kept");
    check("slew", 32'(cfg_out.slew_en), 32'h0);
    check("async pins", 32'(cfg_out.async_pins_alt), 32'h0);
    check("spi pins", 32'(cfg_out.spi_pins_alt), 32'h0);
    check("wdog rate", 32'(cfg_out.watchdog_rate_select), 32'h0);
    $display("Test mixed options done");
    give_verdict();
  end
endmodule // sysopt_regs_bench
